// *** hw/mot_pkg.sv ***
// shared constants, types and helpers of the memory ordering unit
// assumes one core clock and a wrapping age tag handed out in program order
package mot_pkg;

   // ==========================================================
   // sizes and timing
   localparam int AGE_W = 8;
   localparam int PA_W = 44;
   localparam int BLK_LSB = 6;
   localparam int QW_LSB = 3;
   localparam int BLK_W = PA_W - BLK_LSB;
   localparam int QW_PER_BLK = 8;
   localparam int LINE_W = 9;
   localparam int PC_W = 10;
   localparam int STW_ENTRIES = 1024;
   localparam int STW_CLEAR_CYCLES = 16384;
   localparam int LQ_DEPTH = 8;
   localparam int SQ_DEPTH = 8;
   localparam int PEND_DEPTH = 16;
   localparam int MAF_IDX_W = 3;
   localparam int MAF_DEPTH = 8;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      MOT_KIND_LOAD = 3'b000,
      MOT_KIND_STORE = 3'b001,
      MOT_KIND_CSTORE = 3'b010,
      MOT_KIND_WHINT = 3'b011,
      MOT_KIND_EVICT = 3'b100,
      MOT_KIND_IFETCH = 3'b101
   } mot_kind_e;

   typedef enum logic [1:0] {
      MOT_TRAP_LDLD = 2'b00,
      MOT_TRAP_STLD = 2'b01,
      MOT_TRAP_FLOW = 2'b10,
      MOT_TRAP_CONFLICT = 2'b11
   } mot_trap_e;

   typedef struct packed {
      logic valid;
      logic isIo;
      logic [AGE_W-1:0] age;
      logic [PC_W-1:0] pcIdx;
      logic [PA_W-1:0] paddr;
      logic [7:0] bytes;
   } mot_memop_s;

   typedef struct packed {
      logic valid;
      logic isStore;
      logic isIo;
      logic [AGE_W-1:0] age;
   } mot_disp_s;

   typedef struct packed {
      logic valid;
      logic isIo;
      logic waitBit;
      logic [AGE_W-1:0] age;
   } mot_cand_s;

   typedef struct packed {
      logic valid;
      mot_kind_e kind;
      logic [AGE_W-1:0] age;
      logic [PC_W-1:0] pcIdx;
      logic [PA_W-1:0] paddr;
   } mot_miss_s;

   typedef struct packed {
      logic valid;
      mot_kind_e kind;
      logic [BLK_W-1:0] blk;
      logic [QW_PER_BLK-1:0] qwMask;
   } mot_maf_s;

   typedef struct packed {
      logic valid;
      logic merged;
      logic [MAF_IDX_W-1:0] entry;
   } mot_alloc_s;

   typedef struct packed {
      logic valid;
      mot_trap_e kind;
      logic [AGE_W-1:0] age;
      logic [PC_W-1:0] pcIdx;
   } mot_trap_s;

   // ==========================================================
   // helpers
   // a newer than b; ages wrap, so fewer than half the codes may be live
   function automatic logic mot_newer(logic [AGE_W-1:0] a,
                                      logic [AGE_W-1:0] b);
      logic [AGE_W-1:0] d;
      d = a - b;
      return (d != '0) && !d[AGE_W-1];
   endfunction : mot_newer

   function automatic logic mot_aborted(mot_trap_s t, logic [AGE_W-1:0] a);
      return t.valid && !mot_newer(t.age, a);
   endfunction : mot_aborted

   function automatic logic mot_overlap(mot_memop_s a, mot_memop_s b);
      return (a.paddr[PA_W-1:QW_LSB] == b.paddr[PA_W-1:QW_LSB]) &&
             (|(a.bytes & b.bytes));
   endfunction : mot_overlap

   function automatic logic mot_mergeable(mot_kind_e held, mot_kind_e incoming);
      return (held == incoming) ||
             (held == MOT_KIND_STORE && incoming == MOT_KIND_LOAD);
   endfunction : mot_mergeable

   // keep the older of two trap candidates
   function automatic mot_trap_s mot_pick(mot_trap_s cur, mot_trap_s cand);
      if (cand.valid && (!cur.valid || mot_newer(cur.age, cand.age))) begin
         return cand;
      end
      return cur;
   endfunction : mot_pick

endpackage : mot_pkg

// *** hw/mot_wait_table.sv ***
// one-bit-per-entry store-wait table, registered read
// assumes set and clear-all requests come from the same clock domain
module mot_wait_table #(
   parameter int DEPTH = mot_pkg::STW_ENTRIES,
   parameter int IDX_W = mot_pkg::PC_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rdEn,
   input wire logic [IDX_W-1:0] rdIdx,
   output logic rdBit,
   input wire logic setEn,
   input wire logic [IDX_W-1:0] setIdx,
   input wire logic clearAll
);
   import mot_pkg::*;

   logic [DEPTH-1:0] bits_reg, bits_next;
   logic rdBit_reg, rdBit_next;

   // ==========================================================
   // next state
   always_comb begin
      bits_next = clearAll ? '0 : bits_reg;
      // a set in the clearing cycle survives the clear
      if (setEn) begin
         bits_next[setIdx] = 1'b1;
      end
      rdBit_next = rdEn ? bits_reg[rdIdx] : rdBit_reg;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bits_reg <= '0;
         rdBit_reg <= 1'b0;
      end else begin
         bits_reg <= bits_next;
         rdBit_reg <= rdBit_next;
      end
   end

   assign rdBit = rdBit_reg;

endmodule : mot_wait_table

// *** hw/mot_order_unit.sv ***
// memory reference ordering: miss merging, order and replay traps,
// store-wait prediction and issue holds
// assumes the issue queues stop sending aborted work after a trap
module mot_order_unit #(
   parameter int LQ_N = mot_pkg::LQ_DEPTH,
   parameter int SQ_N = mot_pkg::SQ_DEPTH,
   parameter int PEND_N = mot_pkg::PEND_DEPTH,
   parameter int CLEAR_CYCLES = mot_pkg::STW_CLEAR_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic fetchValid,
   input wire logic [mot_pkg::PC_W-1:0] fetchPcIdx,
   output logic fetchWaitBit,
   input wire logic refetchGo,
   input wire mot_pkg::mot_disp_s dispatch,
   input wire mot_pkg::mot_cand_s loadCand,
   input wire mot_pkg::mot_cand_s storeCand,
   output logic loadCanIssue,
   output logic storeCanIssue,
   input wire mot_pkg::mot_memop_s loadIssue,
   input wire mot_pkg::mot_memop_s storeIssue,
   input wire logic loadRetire,
   input wire logic [mot_pkg::AGE_W-1:0] loadRetireAge,
   input wire logic storeRetire,
   input wire logic [mot_pkg::AGE_W-1:0] storeRetireAge,
   input wire mot_pkg::mot_miss_s missReq,
   input wire logic fillValid,
   input wire logic [mot_pkg::MAF_IDX_W-1:0] fillEntry,
   output mot_pkg::mot_alloc_s missAlloc,
   output mot_pkg::mot_trap_s trap
);
   import mot_pkg::*;

   localparam int CLR_W = $clog2(CLEAR_CYCLES);
   localparam logic [CLR_W-1:0] CLR_LAST = CLR_W'(CLEAR_CYCLES - 1);

   mot_memop_s lq_reg [LQ_N];
   mot_memop_s lq_next [LQ_N];
   mot_disp_s sq_reg [SQ_N];
   mot_disp_s sq_next [SQ_N];
   mot_disp_s pend_reg [PEND_N];
   mot_disp_s pend_next [PEND_N];
   mot_maf_s maf_reg [MAF_DEPTH];
   mot_maf_s maf_next [MAF_DEPTH];
   mot_trap_s trap_reg, trap_next, ldldTrap, stldTrap;
   mot_alloc_s alloc_reg, alloc_next;
   logic stwPend_reg, stwPend_next;
   logic [PC_W-1:0] stwIdx_reg, stwIdx_next;
   logic [CLR_W-1:0] clrCnt_reg, clrCnt_next;
   logic clearPulse, stwSetEn;
   logic loadGo, storeGo, missGo, lqFull, sqFull, mafFull;
   logic mergeHit, missConflict;
   logic [MAF_IDX_W-1:0] mergeIdx;
   logic [QW_PER_BLK-1:0] missQw;
   logic olderStore, olderIoLoad, olderIoStore, olderMemStore;

   // ==========================================================
   // order checks against the load queue
   always_comb begin
      ldldTrap = '0;
      stldTrap = '0;
      loadGo = loadIssue.valid && !mot_aborted(trap_reg, loadIssue.age);
      storeGo = storeIssue.valid && !mot_aborted(trap_reg, storeIssue.age);
      lqFull = 1'b1;
      sqFull = 1'b1;
      for (int i = 0; i < LQ_N; i++) begin
         lqFull = lqFull && lq_reg[i].valid;
         if (loadGo && lq_reg[i].valid && mot_overlap(lq_reg[i], loadIssue) &&
             mot_newer(lq_reg[i].age, loadIssue.age)) begin
            ldldTrap = mot_pick(ldldTrap, '{valid: 1'b1, kind: MOT_TRAP_LDLD,
               age: lq_reg[i].age, pcIdx: lq_reg[i].pcIdx});
         end
         if (storeGo && lq_reg[i].valid &&
             mot_overlap(lq_reg[i], storeIssue) &&
             mot_newer(lq_reg[i].age, storeIssue.age)) begin
            stldTrap = mot_pick(stldTrap, '{valid: 1'b1, kind: MOT_TRAP_STLD,
               age: lq_reg[i].age, pcIdx: lq_reg[i].pcIdx});
         end
      end
      for (int i = 0; i < SQ_N; i++) begin
         sqFull = sqFull && sq_reg[i].valid;
      end
   end

   // ==========================================================
   // miss request file lookup
   always_comb begin
      missGo = missReq.valid && !mot_aborted(trap_reg, missReq.age);
      missQw = '0;
      missQw[missReq.paddr[BLK_LSB-1:QW_LSB]] = 1'b1;
      mergeHit = 1'b0;
      mergeIdx = '0;
      missConflict = 1'b0;
      mafFull = 1'b1;
      for (int i = 0; i < MAF_DEPTH; i++) begin
         mafFull = mafFull && maf_reg[i].valid;
         if (maf_reg[i].valid && maf_reg[i].blk == missReq.paddr[PA_W-1:BLK_LSB]
             && mot_mergeable(maf_reg[i].kind, missReq.kind)) begin
            mergeHit = 1'b1;
            mergeIdx = MAF_IDX_W'(i);
         end
         // different block on the same cache line may not be outstanding
         if (maf_reg[i].valid &&
             maf_reg[i].blk[LINE_W-1:0] ==
             missReq.paddr[BLK_LSB+LINE_W-1:BLK_LSB] &&
             maf_reg[i].blk != missReq.paddr[PA_W-1:BLK_LSB]) begin
            missConflict = 1'b1;
         end
      end
   end

   // ==========================================================
   // trap selection: oldest candidate wins, one trap per cycle
   always_comb begin
      trap_next = mot_pick(ldldTrap, stldTrap);
      if (loadGo && lqFull) begin
         trap_next = mot_pick(trap_next, '{valid: 1'b1, kind: MOT_TRAP_FLOW,
            age: loadIssue.age, pcIdx: loadIssue.pcIdx});
      end
      if (storeGo && sqFull) begin
         trap_next = mot_pick(trap_next, '{valid: 1'b1, kind: MOT_TRAP_FLOW,
            age: storeIssue.age, pcIdx: storeIssue.pcIdx});
      end
      if (missGo && !mergeHit && (missConflict || mafFull)) begin
         trap_next = mot_pick(trap_next, '{valid: 1'b1,
            kind: missConflict ? MOT_TRAP_CONFLICT : MOT_TRAP_FLOW,
            age: missReq.age, pcIdx: missReq.pcIdx});
      end
   end

   // ==========================================================
   // queue contents
   always_comb begin
      logic placed;
      placed = 1'b0;
      lq_next = lq_reg;
      sq_next = sq_reg;
      pend_next = pend_reg;
      maf_next = maf_reg;
      alloc_next = '0;
      for (int i = 0; i < LQ_N; i++) begin
         if (mot_aborted(trap_reg, lq_reg[i].age) ||
             (loadRetire && lq_reg[i].age == loadRetireAge)) begin
            lq_next[i].valid = 1'b0;
         end
         if (!placed && !lq_reg[i].valid && loadGo && !lqFull) begin
            lq_next[i] = loadIssue;
            placed = 1'b1;
         end
      end
      placed = 1'b0;
      for (int i = 0; i < SQ_N; i++) begin
         if (mot_aborted(trap_reg, sq_reg[i].age) ||
             (storeRetire && sq_reg[i].age == storeRetireAge)) begin
            sq_next[i].valid = 1'b0;
         end
         if (!placed && !sq_reg[i].valid && storeGo && !sqFull) begin
            sq_next[i] = '{valid: 1'b1, isStore: 1'b1,
                           isIo: storeIssue.isIo, age: storeIssue.age};
            placed = 1'b1;
         end
      end
      // unissued memory ops seen by the issue holds
      placed = 1'b0;
      for (int i = 0; i < PEND_N; i++) begin
         if (mot_aborted(trap_reg, pend_reg[i].age) ||
             (loadIssue.valid && pend_reg[i].age == loadIssue.age) ||
             (storeIssue.valid && pend_reg[i].age == storeIssue.age)) begin
            pend_next[i].valid = 1'b0;
         end
         if (!placed && !pend_reg[i].valid && dispatch.valid &&
             !mot_aborted(trap_reg, dispatch.age)) begin
            pend_next[i] = dispatch;
            placed = 1'b1;
         end
      end
      placed = 1'b0;
      for (int i = 0; i < MAF_DEPTH; i++) begin
         if (fillValid && fillEntry == MAF_IDX_W'(i)) begin
            maf_next[i].valid = 1'b0;
         end
      end
      if (missGo && mergeHit) begin
         // same block, mergeable kind: no new entry, the quadword joins the held one
         maf_next[mergeIdx].qwMask = maf_reg[mergeIdx].qwMask | missQw;
         alloc_next = '{valid: 1'b1, merged: 1'b1, entry: mergeIdx};
      end else if (missGo && !missConflict && !mafFull) begin
         for (int i = 0; i < MAF_DEPTH; i++) begin
            if (!placed && !maf_reg[i].valid) begin
               maf_next[i] = '{valid: 1'b1, kind: missReq.kind,
                  blk: missReq.paddr[PA_W-1:BLK_LSB], qwMask: missQw};
               alloc_next = '{valid: 1'b1, merged: 1'b0,
                              entry: MAF_IDX_W'(i)};
               placed = 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // issue holds
   always_comb begin
      olderStore = 1'b0;
      olderIoLoad = 1'b0;
      olderIoStore = 1'b0;
      olderMemStore = 1'b0;
      for (int i = 0; i < PEND_N; i++) begin
         if (pend_reg[i].valid && pend_reg[i].isStore &&
             mot_newer(loadCand.age, pend_reg[i].age)) begin
            olderStore = 1'b1;
         end
         if (pend_reg[i].valid && !pend_reg[i].isStore && pend_reg[i].isIo &&
             mot_newer(loadCand.age, pend_reg[i].age)) begin
            olderIoLoad = 1'b1;
         end
         if (pend_reg[i].valid && pend_reg[i].isStore &&
             mot_newer(storeCand.age, pend_reg[i].age)) begin
            olderIoStore = olderIoStore || pend_reg[i].isIo;
            olderMemStore = olderMemStore || !pend_reg[i].isIo;
         end
      end
      // load-store pairs to one address rely on the store-load trap
      loadCanIssue = loadCand.valid && !(loadCand.waitBit && olderStore) &&
                     !(loadCand.isIo && olderIoLoad);
      storeCanIssue = storeCand.valid &&
                      !(storeCand.isIo ? olderIoStore : olderMemStore);
   end

   // ==========================================================
   // store-wait set on refetch and periodic clear
   always_comb begin
      clearPulse = (clrCnt_reg == CLR_LAST);
      clrCnt_next = clearPulse ? '0 : clrCnt_reg + 1'b1;
      stwSetEn = refetchGo && stwPend_reg;
      stwPend_next = stwSetEn ? 1'b0 : stwPend_reg;
      stwIdx_next = stwIdx_reg;
      if (trap_reg.valid && trap_reg.kind == MOT_TRAP_STLD) begin
         stwPend_next = 1'b1;
         stwIdx_next = trap_reg.pcIdx;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < LQ_N; i++) lq_reg[i] <= '0;
         for (int i = 0; i < SQ_N; i++) sq_reg[i] <= '0;
         for (int i = 0; i < PEND_N; i++) pend_reg[i] <= '0;
         for (int i = 0; i < MAF_DEPTH; i++) maf_reg[i] <= '0;
         trap_reg <= '0;
         alloc_reg <= '0;
         stwPend_reg <= 1'b0;
         stwIdx_reg <= '0;
         clrCnt_reg <= '0;
      end else begin
         lq_reg <= lq_next;
         sq_reg <= sq_next;
         pend_reg <= pend_next;
         maf_reg <= maf_next;
         trap_reg <= trap_next;
         alloc_reg <= alloc_next;
         stwPend_reg <= stwPend_next;
         stwIdx_reg <= stwIdx_next;
         clrCnt_reg <= clrCnt_next;
      end
   end

   assign trap = trap_reg;
   assign missAlloc = alloc_reg;

   mot_wait_table #(.DEPTH(STW_ENTRIES), .IDX_W(PC_W)) waitTable (
      .clk(clk),
      .sys_rst(sys_rst),
      .rdEn(fetchValid),
      .rdIdx(fetchPcIdx),
      .rdBit(fetchWaitBit),
      .setEn(stwSetEn),
      .setIdx(stwIdx_reg),
      .clearAll(clearPulse)
   );

   // ==========================================================
   // checks
   logic [AGE_W-1:0] lastTrapAge_reg;
   logic lastTrap_reg, lqLeftover;
   always_ff @(posedge clk) begin
      lastTrap_reg <= !sys_rst && trap_reg.valid;
      lastTrapAge_reg <= trap_reg.age;
   end
   always_comb begin
      lqLeftover = 1'b0;
      for (int i = 0; i < LQ_N; i++) begin
         lqLeftover = lqLeftover || (lq_reg[i].valid &&
                      !mot_newer(lastTrapAge_reg, lq_reg[i].age));
      end
   end

   a_flush_newer: assert property (@(posedge clk) disable iff (sys_rst)
      lastTrap_reg |-> !lqLeftover) else $error("aborted load left queued");
   a_ldld_trap: assert property (@(posedge clk) disable iff (sys_rst)
      ldldTrap.valid |=> trap.valid && !mot_newer(trap.age, $past(ldldTrap.age)))
      else $error("load-load trap missed");
   a_stld_trap: assert property (@(posedge clk) disable iff (sys_rst)
      stldTrap.valid |=> trap.valid && !mot_newer(trap.age, $past(stldTrap.age)))
      else $error("store-load trap missed");
   a_flow_target: assert property (@(posedge clk) disable iff (sys_rst)
      (loadGo && lqFull) |=> trap.valid &&
      !mot_newer(trap.age, $past(loadIssue.age)))
      else $error("flow trap not on incoming load");
   a_wait_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (loadCand.waitBit && olderStore) |-> !loadCanIssue)
      else $error("waiting load issued early");
   a_wait_release: assert property (@(posedge clk) disable iff (sys_rst)
      (loadCand.valid && !loadCand.isIo && !olderStore) |-> loadCanIssue)
      else $error("free load still held");
   a_io_order: assert property (@(posedge clk) disable iff (sys_rst)
      (storeCand.isIo && olderIoStore) |-> !storeCanIssue)
      else $error("io store passed older io store");
   a_merge_kind: assert property (@(posedge clk) disable iff (sys_rst)
      (missGo && mergeHit) |=> missAlloc.valid && missAlloc.merged)
      else $error("mergeable miss not merged");
   a_stw_set: assert property (@(posedge clk) disable iff (sys_rst)
      (trap.valid && trap.kind == MOT_TRAP_STLD) ##1 refetchGo |-> stwSetEn)
      else $error("store-wait bit not set on refetch");
   a_clear_period: assert property (@(posedge clk) disable iff (sys_rst)
      clearPulse |=> (clrCnt_reg == '0) && !clearPulse [*8])
      else $error("table clear not periodic");

endmodule : mot_order_unit

// *** verification/mot_fetch_model.sv ***
// partner: fetch pipeline restart after a replay trap
// assumes trap is a registered one-cycle pulse from the order unit
module mot_fetch_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire mot_pkg::mot_trap_s trap,
   output logic refetchGo
);
   timeunit 1ns;
   timeprecision 1ns;
   import mot_pkg::*;
   // ==========================================================
   // restart fetch at the target one cycle after any trap
   // prompt restart only; a slow fetch would just delay the bit write
   always_ff @(posedge clk) begin
      refetchGo <= !sys_rst && trap.valid;
   end
endmodule : mot_fetch_model

// *** verification/tb.sv ***
// self-checking bench of the memory ordering unit
// assumes one core clock, sync reset, clear interval shortened to 64
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import mot_pkg::*;
   localparam int CLR = 64;
   logic clk, sys_rst, fetchValid, fetchWaitBit, refetchGo;
   logic loadCanIssue, storeCanIssue, loadRetire;
   logic [PC_W-1:0] fetchPcIdx;
   logic [AGE_W-1:0] loadRetireAge;
   logic [MAF_IDX_W-1:0] ent;
   mot_disp_s dispatch;
   mot_cand_s loadCand, storeCand;
   mot_memop_s loadIssue, storeIssue;
   mot_miss_s missReq;
   mot_alloc_s missAlloc;
   mot_trap_s trap;
   int nFail = 0;
   int numChecks = 0;
   // ==========================================================
   // design and partner
   mot_order_unit #(.CLEAR_CYCLES(CLR)) dut_u (.clk(clk),
      .sys_rst(sys_rst), .fetchValid(fetchValid), .fetchPcIdx(fetchPcIdx),
      .fetchWaitBit(fetchWaitBit), .refetchGo(refetchGo),
      .dispatch(dispatch), .loadCand(loadCand), .storeCand(storeCand),
      .loadCanIssue(loadCanIssue), .storeCanIssue(storeCanIssue),
      .loadIssue(loadIssue), .storeIssue(storeIssue),
      .loadRetire(loadRetire), .loadRetireAge(loadRetireAge),
      .storeRetire(1'b0), .storeRetireAge(8'h00), .missReq(missReq),
      .fillValid(1'b0), .fillEntry(3'h0), .missAlloc(missAlloc),
      .trap(trap));
   mot_fetch_model fm_u (.clk(clk), .sys_rst(sys_rst), .trap(trap),
      .refetchGo(refetchGo));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ==========================================================
   // helpers
   task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nFail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", numChecks, nFail);
      if (nFail == 0 && numChecks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
   endtask : do_reset
   // ends one negedge after the taking edge, where the answer stands
   task automatic mop(logic st, logic [7:0] age, logic [43:0] pa,
                      logic [9:0] pc);
      @(negedge clk);
      if (st) begin
         storeIssue = '{1'b1, 1'b0, age, pc, pa, 8'hff};
      end else begin
         loadIssue = '{1'b1, 1'b0, age, pc, pa, 8'hff};
      end
      @(negedge clk);
      loadIssue = '0;
      storeIssue = '0;
   endtask : mop
   task automatic miss(mot_kind_e k, logic [7:0] age, logic [43:0] pa);
      @(negedge clk);
      missReq = '{1'b1, k, age, 10'h000, pa};
      @(negedge clk);
      missReq = '0;
   endtask : miss
   task automatic disp(logic st, logic io, logic [7:0] age);
      dispatch = '{1'b1, st, io, age};
      @(negedge clk);
      dispatch = '0;
   endtask : disp
   task automatic fetch(logic [9:0] pc);
      fetchValid = 1'b1;
      fetchPcIdx = pc;
      @(negedge clk);
      fetchValid = 1'b0;
   endtask : fetch
   // ==========================================================
   // scenarios
   task automatic t_ldld();
      do_reset();
      mop(0, 8'h07, 44'h200, 10'h011);
      chk("first load", trap.valid, 0);
      mop(0, 8'h05, 44'h200, 10'h012);
      chk("ldld valid", trap.valid, 1);
      chk("ldld kind", trap.kind, MOT_TRAP_LDLD);
      chk("ldld age", trap.age, 8'h07);
      chk("ldld pc", trap.pcIdx, 10'h011);
      // newer entry must be gone, else this traps again
      mop(0, 8'h06, 44'h200, 10'h013);
      chk("after flush", trap.valid, 0);
      $display("test ldld done");
   endtask : t_ldld
   task automatic t_stld();
      do_reset();
      mop(0, 8'h14, 44'h300, 10'h003);
      mop(1, 8'h12, 44'h304, 10'h000);
      chk("stld kind", trap.kind, MOT_TRAP_STLD);
      chk("stld age", trap.age, 8'h14);
      repeat (2) @(negedge clk);
      fetch(10'h003);
      chk("wait bit set", fetchWaitBit, 1);
      fetch(10'h004);
      chk("other bit", fetchWaitBit, 0);
      repeat (CLR) @(negedge clk);
      fetch(10'h003);
      chk("bit cleared", fetchWaitBit, 0);
      $display("test stld done");
   endtask : t_stld
   task automatic t_hold();
      do_reset();
      disp(1, 0, 8'h1e);
      loadCand = '{1'b1, 1'b0, 1'b1, 8'h1f};
      @(negedge clk) chk("held", loadCanIssue, 0);
      loadCand.waitBit = 1'b0;
      @(negedge clk) chk("no wait bit", loadCanIssue, 1);
      loadCand.waitBit = 1'b1;
      mop(1, 8'h1e, 44'h500, 10'h000);
      chk("released", loadCanIssue, 1);
      loadCand = '0;
      $display("test hold done");
   endtask : t_hold
   task automatic t_order();
      do_reset();
      disp(1, 0, 8'h28);
      disp(1, 1, 8'h2a);
      disp(0, 1, 8'h2c);
      storeCand = '{1'b1, 1'b0, 1'b0, 8'h29};
      @(negedge clk) chk("mem st st", storeCanIssue, 0);
      storeCand = '{1'b1, 1'b1, 1'b0, 8'h2b};
      @(negedge clk) chk("io st st", storeCanIssue, 0);
      storeCand.age = 8'h29;
      @(negedge clk) chk("io st free", storeCanIssue, 1);
      loadCand = '{1'b1, 1'b1, 1'b0, 8'h2d};
      @(negedge clk) chk("io ld ld", loadCanIssue, 0);
      loadCand.isIo = 1'b0;
      @(negedge clk) chk("mem ld free", loadCanIssue, 1);
      loadCand = '0;
      storeCand = '0;
      $display("test order done");
   endtask : t_order
   task automatic t_miss();
      do_reset();
      miss(MOT_KIND_LOAD, 8'h01, 44'h1000);
      chk("new alloc", {missAlloc.valid, missAlloc.merged}, 2'b10);
      ent = missAlloc.entry;
      miss(MOT_KIND_LOAD, 8'h02, 44'h1038);
      chk("merge", {missAlloc.valid, missAlloc.merged}, 2'b11);
      chk("merge entry", missAlloc.entry, ent);
      miss(MOT_KIND_STORE, 8'h03, 44'h1040);
      chk("next block", missAlloc.merged, 0);
      ent = missAlloc.entry;
      miss(MOT_KIND_LOAD, 8'h04, 44'h1048);
      chk("ld into st", {missAlloc.merged, missAlloc.entry}, {1'b1, ent});
      miss(MOT_KIND_STORE, 8'h05, 44'h1008);
      chk("st into ld", {missAlloc.valid, missAlloc.merged}, 2'b10);
      for (int i = 2; i < 6; i++) begin
         miss(mot_kind_e'(i), 8'(2 * i), 44'(44'h4000 + i * 'h40));
         chk("kind new", missAlloc.merged, 0);
         miss(mot_kind_e'(i), 8'(2 * i + 1), 44'(44'h4008 + i * 'h40));
         chk("kind merge", missAlloc.merged, 1);
      end
      miss(MOT_KIND_LOAD, 8'h0e, 44'h9000);
      chk("conflict", {trap.valid, trap.kind}, {1'b1, MOT_TRAP_CONFLICT});
      chk("conflict age", trap.age, 8'h0e);
      chk("no alloc", missAlloc.valid, 0);
      $display("test miss done");
   endtask : t_miss
   task automatic t_flow();
      do_reset();
      for (int i = 0; i < LQ_DEPTH; i++) begin
         mop(0, 8'(8'h40 + i), 44'(i * 'h100), 10'h000);
         chk("ld fill", trap.valid, 0);
      end
      mop(0, 8'h48, 44'h900, 10'h000);
      chk("flow", {trap.valid, trap.kind}, {1'b1, MOT_TRAP_FLOW});
      chk("flow age", trap.age, 8'h48);
      loadRetire = 1'b1;
      loadRetireAge = 8'h40;
      @(negedge clk);
      loadRetire = 1'b0;
      mop(0, 8'h49, 44'ha00, 10'h000);
      chk("room again", trap.valid, 0);
      $display("test flow done");
   endtask : t_flow
   // ==========================================================
   // main sequence and watchdog
   initial begin
      sys_rst = 1'b1;
      fetchValid = 1'b0;
      fetchPcIdx = '0;
      loadRetire = 1'b0;
      loadRetireAge = '0;
      dispatch = '0;
      loadCand = '0;
      storeCand = '0;
      loadIssue = '0;
      storeIssue = '0;
      missReq = '0;
      t_ldld();
      t_stld();
      t_hold();
      t_order();
      t_miss();
      t_flow();
      end_of_test();
   end
   // about 190 cycles expected; generous margin
   initial begin
      #(2000 * 100);
      nFail++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule : tb
